// ---- dv/cpu_irq_sysreg_asserts.sv ----
// Purpose: port-level checks
// Assumes: each request answered one cycle later
// Notes:   attached to every instance by bind
`timescale 1ns/1ns
`default_nettype none
module cpu_irq_sysreg_asserts (
  // clock, reset and request
  input wire logic        core_clk, sys_rst, reqValid, reqWrite,
  input wire logic [1:0]  reqOp0, curEl,
  input wire logic [2:0]  reqOp1, reqOp2,
  input wire logic [3:0]  reqCrn, reqCrm,
  // context
  input wire logic        irqMasked, sreEl1, sreEl3, el3Present,
  input wire logic        el2Enabled, splitModeEl1,
  // response
  input wire logic        respValid, respUndef, respTrap, ackPulse,
  input wire logic        eoiPulse, eoiDeactivate, fiqReq,
  input wire logic [1:0]  respTrapEl,
  input wire logic [5:0]  respTrapClass,
  input wire logic [63:0] respData,
  input wire logic [23:0] ackId
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic peek = reqValid && !reqWrite && reqOp0 == 2'h3 && reqOp1 == 3'h0
    && reqCrn == 4'hc && reqOp2 == 3'h2 && (reqCrm == 4'h8 || reqCrm == 4'hc);
  sequence s_ackMasked;
    ackPulse && $past(irqMasked);
  endsequence
  property p_app; peek && curEl == 2'h0 |=> respUndef; endproperty
  a_app: assert property (p_app) else $error("app not undef");
  property p_kern;
    peek && curEl == 2'h1 && !sreEl1 && !el3Present |=> respTrap
      && respTrapEl == 2'h1;
  endproperty
  a_kern: assert property (p_kern) else $error("kernel trap");
  property p_mon;
    peek && curEl == 2'h3 |=> respTrap != $past(sreEl3)
      && (!respTrap || respTrapEl == 2'h3);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor trap");
  property p_cls; respTrap |-> respValid && respTrapClass == 6'h18; endproperty
  a_cls: assert property (p_cls) else $error("trap class");
  property p_res; peek && !el2Enabled |=> respData[63:24] == 40'h0; endproperty
  a_res: assert property (p_res) else $error("upper bits");
  property p_side; peek |=> !ackPulse && !eoiPulse; endproperty
  a_side: assert property (p_side) else $error("peek side effect");
  property p_ack;
    ackPulse |-> respValid && respData[23:0] == ackId
      && (ackId < 24'h3fc || ackId > 24'h3ff);
  endproperty
  a_ack: assert property (p_ack) else $error("ack id");
  property p_sync; s_ackMasked |-> !fiqReq [*3]; endproperty
  a_sync: assert property (p_sync) else $error("fiq after ack");
  property p_deact;
    eoiPulse && !$past(el3Present) |-> eoiDeactivate == !$past(splitModeEl1);
  endproperty
  a_deact: assert property (p_deact) else $error("eoi deactivate");
endmodule : cpu_irq_sysreg_asserts
bind cpu_irq_sysreg cpu_irq_sysreg_asserts i_chk (.*);
`default_nettype wire

// ---- dv/cpu_irq_sysreg_tb_top.sv ----
// Purpose: directed tests of the register block
// Assumes: answer one cycle after a request
// Notes:   flags are valid, undef, trap, trap level, ack, eoi
`timescale 1ns/1ns
`default_nettype none
module cpu_irq_sysreg_tb_top;
  localparam logic [6:0] OK = 7'h40, UND = 7'h60, ACK = 7'h42, EOI = 7'h41;
  localparam logic [6:0] T1 = 7'h54, T2 = 7'h58, T3 = 7'h5c;
  logic core_clk = 1'h0, sys_rst = 1'h1, reqValid = 1'h0, reqWrite = 1'h0;
  logic [1:0] reqOp0 = 2'h3, curEl = 2'h1, respTrapEl;
  logic [2:0] reqOp1 = 3'h0, reqOp2 = 3'h0;
  logic [3:0] reqCrn = 4'hc, reqCrm = 4'h0;
  logic [5:0] respTrapClass;
  logic [63:0] reqWdata = 64'h0, respData;
  logic [63:0] virtGroup0Peek = 64'hffff0000_00000abc;
  logic [63:0] virtGroup1Peek = 64'h0000ffff_00000def;
  logic secureState = 1'h0, irqMasked = 1'h0, sreEl1 = 1'h1, sreEl2 = 1'h1;
  logic sreEl3 = 1'h1, el2Enabled = 1'h0, el3Present = 1'h0, raise = 1'h0;
  logic trapAllGroup0 = 1'h0, trapAllGroup1 = 1'h0, monRouteFiq = 1'h0;
  logic fastIrqVirtOverride = 1'h0, normalIrqVirtOverride = 1'h0;
  logic monRouteIrq = 1'h0, monUndefPriority = 1'h0;
  logic monitorUndefNotTrap = 1'h0, splitModeEl1 = 1'h0, idBits24 = 1'h1;
  logic splitModeEl1S = 1'h0, splitModeEl1Ns = 1'h0, splitModeEl3 = 1'h0;
  logic pend0Visible = 1'h1, pend0Sufficient = 1'h1, pend0HiddenNs = 1'h0;
  logic pend1Visible = 1'h1, pend1Sufficient = 1'h1, pend1HiddenNs = 1'h0;
  logic pend1Valid = 1'h1, pend0Valid, respValid, respUndef, respTrap;
  logic ackPulse, eoiPulse, eoiDeactivate, eoiVirtual, fiqReq, irqReq;
  logic [23:0] raiseId = 24'h0, pend1Id = 24'h000456, pend0Id, ackId, eoiId;
  int miscompares = 0;
  int checksDone = 0;

  cpu_irq_sysreg i_dut (.*);
  irq_source_model i_src (.core_clk(core_clk), .sys_rst(sys_rst),
    .ackPulse(ackPulse), .raise(raise), .raiseId(raiseId),
    .pendValid(pend0Valid), .pendId(pend0Id));

  initial forever #10 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [70:0] s, e);
    checksDone++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [3:0] m, input logic [2:0] o,
                     input logic [6:0] ef, input logic [63:0] ed);
    @(posedge core_clk);
    {reqValid, reqWrite, reqCrm, reqOp2} <= {1'h1, w, m, o};
    reqWdata <= ed;
    @(posedge core_clk);
    reqValid <= 1'h0;
    #1;
    chk("response", {respValid, respUndef, respTrap, respTrapEl, ackPulse,
        eoiPulse, respData}, {ef, w ? 64'h0 : ed});
    @(posedge core_clk);
  endtask : acc

  task automatic pk(input logic g, input logic [6:0] ef, input logic [63:0] ed);
    acc(1'h0, g ? 4'hc : 4'h8, 3'h2, ef, ed);
  endtask : pk

  task automatic give(input logic [23:0] id);
    {raise, raiseId} <= {1'h1, id};
    @(posedge core_clk);
    raise <= 1'h0;
  endtask : give

  task automatic summarize();
    if (miscompares == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'h0;
    give(24'h000123);
    pk(1'h0, OK, 64'h123);
    pk(1'h0, OK, 64'h123);
    pk(1'h1, OK, 64'h456);
    acc(1'h0, 4'h8, 3'h3, UND, 64'h0);
    acc(1'h1, 4'hc, 3'h2, UND, 64'h0);
    reqOp1 <= 3'h1;
    pk(1'h0, UND, 64'h0);
    {reqOp1, irqMasked} <= 4'h1;
    acc(1'h0, 4'h8, 3'h0, ACK, 64'h123);
    chk("ackId", 71'(ackId), 71'h123);
    irqMasked <= 1'h0;
    pk(1'h0, OK, 64'h3ff);
    give(24'h000077);
    {pend0Sufficient, pend0HiddenNs} <= 2'h1;
    acc(1'h0, 4'h8, 3'h0, OK, 64'h3fd);
    {pend0Visible, pend0Sufficient, pend0HiddenNs} <= 3'h2;
    pk(1'h0, OK, 64'h3fc);
    {pend1Visible, pend1HiddenNs, pend0Visible} <= 3'h3;
    pk(1'h1, OK, 64'h3fd);
    pend1Valid <= 1'h0;
    pk(1'h1, OK, 64'h3ff);
    {pend1Valid, pend1Visible, pend1Id} <= {2'h3, 24'hab0456};
    pk(1'h1, OK, 64'hab0456);
    idBits24 <= 1'h0;
    pk(1'h1, OK, 64'h456);
    {idBits24, curEl} <= 3'h4;
    pk(1'h0, UND, 64'h0);
    {curEl, sreEl1} <= 3'h2;
    pk(1'h0, T1, 64'h0);
    {sreEl1, el2Enabled, trapAllGroup0} <= 3'h7;
    pk(1'h0, T2, 64'h0);
    pk(1'h1, OK, 64'hab0456);
    {trapAllGroup0, fastIrqVirtOverride, trapAllGroup1} <= 3'h3;
    pk(1'h0, OK, virtGroup0Peek);
    pk(1'h1, T2, 64'h0);
    {trapAllGroup1, normalIrqVirtOverride} <= 2'h1;
    pk(1'h1, OK, virtGroup1Peek);
    {el2Enabled, el3Present, monRouteFiq, monRouteIrq} <= 4'h7;
    pk(1'h0, T3, 64'h0);
    pk(1'h1, T3, 64'h0);
    monitorUndefNotTrap <= 1'h1;
    pk(1'h0, UND, 64'h0);
    {sreEl1, monUndefPriority, monitorUndefNotTrap} <= 3'h2;
    pk(1'h0, UND, 64'h0);
    {curEl, sreEl2, sreEl1, monRouteFiq} <= 5'h12;
    pk(1'h0, T2, 64'h0);
    {curEl, sreEl3} <= 3'h6;
    pk(1'h0, T3, 64'h0);
    sreEl3 <= 1'h1;
    pk(1'h0, OK, 64'h77);
    {curEl, el3Present, splitModeEl1, secureState} <= 5'h0b;
    acc(1'h1, 4'hc, 3'h1, EOI, 64'h456);
    chk("eoiId", 71'(eoiId), 71'h456);
    splitModeEl1 <= 1'h0;
    acc(1'h1, 4'hc, 3'h1, EOI, 64'h456);
    acc(1'h1, 4'hc, 3'h1, OK, 64'h3ff);
    chk("eoiId", 71'(eoiId), 71'h456);
    summarize();
  end
endmodule : cpu_irq_sysreg_tb_top
`default_nettype wire

// ---- dv/irq_source_model.sv ----
// Purpose: group 0 pending source for the tests
// Assumes: a raise wins over a same-cycle acknowledge
// Notes:   the id scrambles while nothing is pending
`timescale 1ns/1ns
`default_nettype none
module irq_source_model (
  // clock, reset and control
  input  wire logic        core_clk, sys_rst, ackPulse, raise,
  input  wire logic [23:0] raiseId,
  // pending view
  output var  logic        pendValid,
  output var  logic [23:0] pendId
);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {pendValid, pendId} <= 25'h0;
    end else if (raise) begin
      {pendValid, pendId} <= {1'h1, raiseId};
    end else begin
      pendValid <= pendValid && !ackPulse;
      pendId    <= pendValid ? pendId : ~pendId;
    end
  end
endmodule : irq_source_model
`default_nettype wire

// ---- hw/access_check.sv ----
// Purpose: undefined, trap, virtual or physical for one group
// Assumes: the parent selects the group's bits
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module access_check (
  // context
  sysreg_ctx_if.chk              ctx,
  // group routing bits
  input  wire logic              trapAllGroup,
  input  wire logic              virtOverride,
  input  wire logic              routedToMonitor,
  // decision
  output cpu_irq_pkg::access_t   decision,
  output logic [1:0]             trapEl
);
  logic monRoute;
  logic monUndef;
  logic undefFirst;
  cpu_irq_pkg::access_t monDec;

  assign monRoute   = ctx.el3Present && routedToMonitor;
  assign undefFirst = monRoute && ctx.monUndefPriority;
  assign monUndef   = ctx.monitorUndefNotTrap;
  assign monDec     = monUndef ? cpu_irq_pkg::ACC_UNDEF
                               : cpu_irq_pkg::ACC_TRAP;

  always_comb begin
    decision = cpu_irq_pkg::ACC_PHYS;
    trapEl   = cpu_irq_pkg::EL_MON;
    case (ctx.curEl)
      cpu_irq_pkg::EL_APP: begin
        decision = cpu_irq_pkg::ACC_UNDEF;
      end
      cpu_irq_pkg::EL_KERN: begin
        if (undefFirst) begin
          decision = cpu_irq_pkg::ACC_UNDEF;
        end else if (!ctx.sreEl1) begin
          decision = cpu_irq_pkg::ACC_TRAP;
          trapEl   = cpu_irq_pkg::EL_KERN;
        end else if (ctx.el2Enabled && trapAllGroup) begin
          decision = cpu_irq_pkg::ACC_TRAP;
          trapEl   = cpu_irq_pkg::EL_HYP;
        end else if (ctx.el2Enabled && virtOverride) begin
          decision = cpu_irq_pkg::ACC_VIRT;
        end else if (monRoute) begin
          decision = monDec;
        end
      end
      cpu_irq_pkg::EL_HYP: begin
        if (undefFirst) begin
          decision = cpu_irq_pkg::ACC_UNDEF;
        end else if (!ctx.sreEl2) begin
          decision = cpu_irq_pkg::ACC_TRAP;
          trapEl   = cpu_irq_pkg::EL_HYP;
        end else if (monRoute) begin
          decision = monDec;
        end
      end
      default: begin
        if (!ctx.sreEl3) begin
          decision = cpu_irq_pkg::ACC_TRAP;
        end
      end
    endcase
  end
endmodule : access_check
`default_nettype wire

// ---- hw/cpu_irq_pkg.sv ----
// Purpose: shared constants and types of the cpu interrupt register block
// Assumes: encodings arrive split into fields
// Notes:   24-bit identifiers; 16-bit builds mask
package cpu_irq_pkg;

  // system-register encoding fields
  localparam logic [1:0] ENC_OP0      = 2'h3;
  localparam logic [2:0] ENC_OP1      = 3'h0;
  localparam logic [3:0] ENC_CRN      = 4'hc;
  localparam logic [3:0] ENC_CRM_G0   = 4'h8;
  localparam logic [3:0] ENC_CRM_G1   = 4'hc;
  localparam logic [2:0] ENC_OP2_PEEK = 3'h2;
  localparam logic [2:0] ENC_OP2_ACK  = 3'h0;
  localparam logic [2:0] ENC_OP2_EOI  = 3'h1;

  // register layout
  localparam int         DATA_W   = 64;
  localparam int         ID_W     = 24;
  localparam int         ID_LO_W  = 16;
  localparam logic [DATA_W-ID_W-1:0] RES0_HI = 40'h0;
  localparam logic [ID_W-ID_LO_W-1:0] RES0_ID = 8'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 64'h0;

  // special identifiers
  localparam logic [ID_W-1:0] ID_SPEC_SECURE = 24'h0003fc;
  localparam logic [ID_W-1:0] ID_SPEC_NONSEC = 24'h0003fd;
  localparam logic [ID_W-1:0] ID_SPEC_NONE   = 24'h0003ff;
  localparam logic [ID_W-1:0] ID_ZERO        = 24'h000000;

  // exception levels and trap class
  localparam logic [1:0] EL_APP  = 2'h0;
  localparam logic [1:0] EL_KERN = 2'h1;
  localparam logic [1:0] EL_HYP  = 2'h2;
  localparam logic [1:0] EL_MON  = 2'h3;
  localparam logic [5:0] TRAP_CLASS_SYSREG = 6'h18;

  // cycles the line stays low after a masked ack
  localparam logic [1:0] ACK_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    ACC_PHYS,
    ACC_VIRT,
    ACC_UNDEF,
    ACC_TRAP
  } access_t;

  function automatic logic isSpecial(input logic [ID_W-1:0] id);
    isSpecial = (id >= ID_SPEC_SECURE) && (id <= ID_SPEC_NONE);
  endfunction : isSpecial

  function automatic logic encMatch(
    input logic [1:0] op0, input logic [2:0] op1, input logic [3:0] crn,
    input logic [3:0] crm, input logic [2:0] op2,
    input logic [3:0] wantCrm, input logic [2:0] wantOp2);
    encMatch = (op0 == ENC_OP0) && (op1 == ENC_OP1) && (crn == ENC_CRN)
               && (crm == wantCrm) && (op2 == wantOp2);
  endfunction : encMatch

endpackage : cpu_irq_pkg

// ---- hw/cpu_irq_sysreg.sv ----
// Purpose: pending-peek, group 0 acknowledge and
//          group 1 end-of-interrupt registers
// Assumes: one request per cycle, answered on the following cycle
// Notes:   arbiter view updates after ackPulse/eoiPulse
// Function
// - ack valid only for non-special identifiers
// - eoi with special identifier is ignored
// - group 0 peek encoding 3,0,12,8,2
// - group 1 peek encoding 3,0,12,12,2
// - group 0 peek returns highest pending group 0
// - group 1 peek returns highest pending group 1
// - unobservable pending returns 1020, 1021 or 1023
// - id in bits 23:0, upper zero except for virtual peeks
// - group 0 ack returns id and activates it
// - ack needs sufficient priority and acknowledgeable
// - ack reads self-synchronise while interrupts masked
// - application level access is undefined
// - kernel level, enable clear, trap to kernel
// - trap-all-group0 traps group 0 to hypervisor
// - fast override reads virtual group 0 peek
// - group 1 uses trap-all-group1 and normal override
// - monitor routing traps or is undefined
// - hypervisor level, enable clear, trap to hypervisor
// - monitor level, enable clear traps, else physical
// - eoi drops priority, deactivates unless split mode
`timescale 1ns/1ns
`default_nettype none
module cpu_irq_sysreg (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // system-register request
  input  wire logic                          reqValid,
  input  wire logic                          reqWrite,
  input  wire logic [1:0]                    reqOp0,
  input  wire logic [2:0]                    reqOp1,
  input  wire logic [3:0]                    reqCrn,
  input  wire logic [3:0]                    reqCrm,
  input  wire logic [2:0]                    reqOp2,
  input  wire logic [cpu_irq_pkg::DATA_W-1:0] reqWdata,
  // processor state
  input  wire logic [1:0]                    curEl,
  input  wire logic                          secureState,
  input  wire logic                          irqMasked,
  // enables and routing
  input  wire logic                          sreEl1,
  input  wire logic                          sreEl2,
  input  wire logic                          sreEl3,
  input  wire logic                          el2Enabled,
  input  wire logic                          el3Present,
  input  wire logic                          trapAllGroup0,
  input  wire logic                          trapAllGroup1,
  input  wire logic                          fastIrqVirtOverride,
  input  wire logic                          normalIrqVirtOverride,
  input  wire logic                          monRouteFiq,
  input  wire logic                          monRouteIrq,
  input  wire logic                          monUndefPriority,
  input  wire logic                          monitorUndefNotTrap,
  input  wire logic                          splitModeEl1,
  input  wire logic                          splitModeEl1S,
  input  wire logic                          splitModeEl1Ns,
  input  wire logic                          splitModeEl3,
  input  wire logic                          idBits24,
  // arbiter view, group 0
  input  wire logic                          pend0Valid,
  input  wire logic [cpu_irq_pkg::ID_W-1:0]  pend0Id,
  input  wire logic                          pend0Visible,
  input  wire logic                          pend0Sufficient,
  input  wire logic                          pend0HiddenNs,
  // arbiter view, group 1
  input  wire logic                          pend1Valid,
  input  wire logic [cpu_irq_pkg::ID_W-1:0]  pend1Id,
  input  wire logic                          pend1Visible,
  input  wire logic                          pend1Sufficient,
  input  wire logic                          pend1HiddenNs,
  // virtual interface peek values
  input  wire logic [cpu_irq_pkg::DATA_W-1:0] virtGroup0Peek,
  input  wire logic [cpu_irq_pkg::DATA_W-1:0] virtGroup1Peek,
  // response
  output logic                               respValid,
  output logic [cpu_irq_pkg::DATA_W-1:0]     respData,
  output logic                               respUndef,
  output logic                               respTrap,
  output logic [1:0]                         respTrapEl,
  output logic [5:0]                         respTrapClass,
  // acknowledge and end-of-interrupt to arbiter
  output logic                               ackPulse,
  output logic [cpu_irq_pkg::ID_W-1:0]       ackId,
  output logic                               eoiPulse,
  output logic [cpu_irq_pkg::ID_W-1:0]       eoiId,
  output logic                               eoiDeactivate,
  output logic                               eoiVirtual,
  // signalled interrupt lines
  output logic                               fiqReq,
  output logic                               irqReq
);
  sysreg_ctx_if ctx ();

  cpu_irq_pkg::access_t acc0;
  cpu_irq_pkg::access_t acc1;
  cpu_irq_pkg::access_t accSel;
  logic [1:0] trapEl0;
  logic [1:0] trapEl1;
  logic [1:0] trapElSel;
  logic [cpu_irq_pkg::ID_W-1:0] peek0Id;
  logic [cpu_irq_pkg::ID_W-1:0] peek1Id;
  logic [cpu_irq_pkg::ID_W-1:0] ack0Id;
  logic [cpu_irq_pkg::ID_W-1:0] wrId;
  logic ack0Real;
  logic hitPeek0;
  logic hitPeek1;
  logic hitAck0;
  logic hitEoi1;
  logic hitG0;
  logic mapped;
  logic accOk;
  logic doAck;
  logic doEoi;
  logic splitMode;
  logic [cpu_irq_pkg::DATA_W-1:0] readData;

  logic                           respValid_r, respValid_nxt;
  logic [cpu_irq_pkg::DATA_W-1:0] respData_r, respData_nxt;
  logic                           respUndef_r, respUndef_nxt;
  logic                           respTrap_r, respTrap_nxt;
  logic [1:0]                     respTrapEl_r, respTrapEl_nxt;
  logic [5:0]                     respTrapClass_r, respTrapClass_nxt;
  logic                           ackPulse_r;
  logic [cpu_irq_pkg::ID_W-1:0]   ackId_r;
  logic                           eoiPulse_r;
  logic [cpu_irq_pkg::ID_W-1:0]   eoiId_r;
  logic                           eoiDeact_r;
  logic                           eoiVirt_r;
  logic                           fiqReq_r, fiqReq_nxt;
  logic                           irqReq_r;
  logic [1:0]                     settle_r, settle_nxt;

  // context to the checkers
  assign ctx.curEl               = curEl;
  assign ctx.el2Enabled          = el2Enabled;
  assign ctx.el3Present          = el3Present;
  assign ctx.sreEl1              = sreEl1;
  assign ctx.sreEl2              = sreEl2;
  assign ctx.sreEl3              = sreEl3;
  assign ctx.monUndefPriority    = monUndefPriority;
  assign ctx.monitorUndefNotTrap = monitorUndefNotTrap;

  access_check chk0 (
    .ctx             (ctx),
    .trapAllGroup    (trapAllGroup0),
    .virtOverride    (fastIrqVirtOverride),
    .routedToMonitor (monRouteFiq),
    .decision        (acc0),
    .trapEl          (trapEl0)
  );

  access_check chk1 (
    .ctx             (ctx),
    .trapAllGroup    (trapAllGroup1),
    .virtOverride    (normalIrqVirtOverride),
    .routedToMonitor (monRouteIrq),
    .decision        (acc1),
    .trapEl          (trapEl1)
  );

  id_select sel0 (
    .pendValid       (pend0Valid),
    .pendId          (pend0Id),
    .pendVisible     (pend0Visible),
    .pendSufficient  (pend0Sufficient),
    .hiddenNonSecure (pend0HiddenNs),
    .needSufficient  (1'b0),
    .idBits24        (idBits24),
    .id              (peek0Id),
    .isReal          ()
  );

  id_select sel1 (
    .pendValid       (pend1Valid),
    .pendId          (pend1Id),
    .pendVisible     (pend1Visible),
    .pendSufficient  (pend1Sufficient),
    .hiddenNonSecure (pend1HiddenNs),
    .needSufficient  (1'b0),
    .idBits24        (idBits24),
    .id              (peek1Id),
    .isReal          ()
  );

  id_select selAck (
    .pendValid       (pend0Valid),
    .pendId          (pend0Id),
    .pendVisible     (pend0Visible),
    .pendSufficient  (pend0Sufficient),
    .hiddenNonSecure (pend0HiddenNs),
    .needSufficient  (1'b1),
    .idBits24        (idBits24),
    .id              (ack0Id),
    .isReal          (ack0Real)
  );

  // direction must match the register's access
  assign hitPeek0 = !reqWrite && cpu_irq_pkg::encMatch(reqOp0, reqOp1,
    reqCrn, reqCrm, reqOp2, cpu_irq_pkg::ENC_CRM_G0,
    cpu_irq_pkg::ENC_OP2_PEEK);
  assign hitPeek1 = !reqWrite && cpu_irq_pkg::encMatch(reqOp0, reqOp1,
    reqCrn, reqCrm, reqOp2, cpu_irq_pkg::ENC_CRM_G1,
    cpu_irq_pkg::ENC_OP2_PEEK);
  assign hitAck0 = !reqWrite && cpu_irq_pkg::encMatch(reqOp0, reqOp1,
    reqCrn, reqCrm, reqOp2, cpu_irq_pkg::ENC_CRM_G0,
    cpu_irq_pkg::ENC_OP2_ACK);
  assign hitEoi1 = reqWrite && cpu_irq_pkg::encMatch(reqOp0, reqOp1,
    reqCrn, reqCrm, reqOp2, cpu_irq_pkg::ENC_CRM_G1,
    cpu_irq_pkg::ENC_OP2_EOI);

  assign hitG0     = hitPeek0 || hitAck0;
  assign mapped    = hitG0 || hitPeek1 || hitEoi1;
  assign accSel    = hitG0 ? acc0 : acc1;
  assign trapElSel = hitG0 ? trapEl0 : trapEl1;
  assign accOk     = (accSel == cpu_irq_pkg::ACC_PHYS)
                     || (accSel == cpu_irq_pkg::ACC_VIRT);

  // ack only physical reads of a real id
  assign doAck = reqValid && hitAck0
                 && (accSel == cpu_irq_pkg::ACC_PHYS)
                 && ack0Real;

  assign wrId = idBits24 ? reqWdata[cpu_irq_pkg::ID_W-1:0]
                : {cpu_irq_pkg::RES0_ID,
                   reqWdata[cpu_irq_pkg::ID_LO_W-1:0]};
  assign doEoi = reqValid && hitEoi1 && accOk
                 && !cpu_irq_pkg::isSpecial(wrId);

  assign splitMode = !el3Present ? splitModeEl1
                   : (curEl == cpu_irq_pkg::EL_MON) ? splitModeEl3
                   : (secureState ? splitModeEl1S : splitModeEl1Ns);

  // read data, upper bits zero except for virtual peeks
  always_comb begin
    readData = cpu_irq_pkg::DATA_ZERO;
    if (hitPeek0) begin
      readData = (acc0 == cpu_irq_pkg::ACC_VIRT) ? virtGroup0Peek
                 : {cpu_irq_pkg::RES0_HI, peek0Id};
    end else if (hitPeek1) begin
      readData = (acc1 == cpu_irq_pkg::ACC_VIRT) ? virtGroup1Peek
                 : {cpu_irq_pkg::RES0_HI, peek1Id};
    end else if (hitAck0) begin
      readData = {cpu_irq_pkg::RES0_HI, ack0Id};
    end
  end

  always_comb begin
    respValid_nxt     = reqValid;
    respData_nxt      = cpu_irq_pkg::DATA_ZERO;
    respUndef_nxt     = 1'b0;
    respTrap_nxt      = 1'b0;
    respTrapEl_nxt    = cpu_irq_pkg::EL_APP;
    respTrapClass_nxt = 6'h00;
    if (reqValid) begin
      if (!mapped || accSel == cpu_irq_pkg::ACC_UNDEF) begin
        respUndef_nxt = 1'b1;
      end else if (accSel == cpu_irq_pkg::ACC_TRAP) begin
        respTrap_nxt      = 1'b1;
        respTrapEl_nxt    = trapElSel;
        respTrapClass_nxt = cpu_irq_pkg::TRAP_CLASS_SYSREG;
      end else if (!reqWrite) begin
        respData_nxt = readData;
      end
    end
  end

  // after a masked ack the line stays low
  // until the arbiter has caught up, so an
  // immediate unmask sees no stale request
  always_comb begin
    settle_nxt = (settle_r != 2'h0) ? settle_r - 2'h1 : 2'h0;
    if (doAck && irqMasked) begin
      settle_nxt = cpu_irq_pkg::ACK_SETTLE;
    end
    fiqReq_nxt = pend0Valid && pend0Visible && pend0Sufficient
                 && !(doAck && irqMasked) && (settle_nxt == 2'h0);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      respValid_r     <= 1'b0;
      respData_r      <= cpu_irq_pkg::DATA_ZERO;
      respUndef_r     <= 1'b0;
      respTrap_r      <= 1'b0;
      respTrapEl_r    <= cpu_irq_pkg::EL_APP;
      respTrapClass_r <= 6'h00;
      settle_r        <= 2'h0;
      fiqReq_r        <= 1'b0;
      irqReq_r        <= 1'b0;
    end else begin
      respValid_r     <= respValid_nxt;
      respData_r      <= respData_nxt;
      respUndef_r     <= respUndef_nxt;
      respTrap_r      <= respTrap_nxt;
      respTrapEl_r    <= respTrapEl_nxt;
      respTrapClass_r <= respTrapClass_nxt;
      settle_r        <= settle_nxt;
      fiqReq_r        <= fiqReq_nxt;
      irqReq_r        <= pend1Valid && pend1Visible && pend1Sufficient;
    end
  end

  // peeks never reach these strobes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ackPulse_r <= 1'b0;
      ackId_r    <= cpu_irq_pkg::ID_ZERO;
      eoiPulse_r <= 1'b0;
      eoiId_r    <= cpu_irq_pkg::ID_ZERO;
      eoiDeact_r <= 1'b0;
      eoiVirt_r  <= 1'b0;
    end else begin
      ackPulse_r <= doAck;
      ackId_r    <= doAck ? ack0Id : ackId_r;
      eoiPulse_r <= doEoi;
      if (doEoi) begin
        eoiId_r    <= wrId;
        eoiDeact_r <= !splitMode;
        eoiVirt_r  <= (acc1 == cpu_irq_pkg::ACC_VIRT);
      end
    end
  end

  assign respValid     = respValid_r;
  assign respData      = respData_r;
  assign respUndef     = respUndef_r;
  assign respTrap      = respTrap_r;
  assign respTrapEl    = respTrapEl_r;
  assign respTrapClass = respTrapClass_r;
  assign ackPulse      = ackPulse_r;
  assign ackId         = ackId_r;
  assign eoiPulse      = eoiPulse_r;
  assign eoiId         = eoiId_r;
  assign eoiDeactivate = eoiDeact_r;
  assign eoiVirtual    = eoiVirt_r;
  assign fiqReq        = fiqReq_r;
  assign irqReq        = irqReq_r;
endmodule : cpu_irq_sysreg
`default_nettype wire

// ---- hw/id_select.sv ----
// Purpose: pick the identifier a read returns, or a special one
// Assumes: pending id and flags come from the arbiter
// Notes:   masks the top byte in 16-bit builds
`timescale 1ns/1ns
`default_nettype none
module id_select (
  // arbiter view
  input  wire logic                          pendValid,
  input  wire logic [cpu_irq_pkg::ID_W-1:0]  pendId,
  input  wire logic                          pendVisible,
  input  wire logic                          pendSufficient,
  input  wire logic                          hiddenNonSecure,
  // options
  input  wire logic                          needSufficient,
  input  wire logic                          idBits24,
  // result
  output logic [cpu_irq_pkg::ID_W-1:0]       id,
  output logic                               isReal
);
  logic                         usable;
  logic [cpu_irq_pkg::ID_W-1:0] masked;
  logic [cpu_irq_pkg::ID_W-1:0] hidden;

  assign usable = pendValid && pendVisible
                  && (pendSufficient || !needSufficient);
  assign masked = idBits24 ? pendId
                  : {cpu_irq_pkg::RES0_ID,
                     pendId[cpu_irq_pkg::ID_LO_W-1:0]};
  assign hidden = hiddenNonSecure ? cpu_irq_pkg::ID_SPEC_NONSEC
                                  : cpu_irq_pkg::ID_SPEC_SECURE;
  assign id = !pendValid ? cpu_irq_pkg::ID_SPEC_NONE
              : (usable ? masked : hidden);
  assign isReal = usable && !cpu_irq_pkg::isSpecial(masked);
endmodule : id_select
`default_nettype wire

// ---- hw/sysreg_ctx_if.sv ----
// Purpose: context shared by the access checkers
// Assumes: levels valid in the request cycle
// Notes:   top drives src, checkers read chk
`timescale 1ns/1ns
`default_nettype none
interface sysreg_ctx_if;
  logic [1:0] curEl;
  logic       el2Enabled;
  logic       el3Present;
  logic       sreEl1;
  logic       sreEl2;
  logic       sreEl3;
  logic       monUndefPriority;
  logic       monitorUndefNotTrap;

  modport src (output curEl, el2Enabled, el3Present, sreEl1, sreEl2,
               sreEl3, monUndefPriority, monitorUndefNotTrap);
  modport chk (input curEl, el2Enabled, el3Present, sreEl1, sreEl2,
               sreEl3, monUndefPriority, monitorUndefNotTrap);
endinterface : sysreg_ctx_if
`default_nettype wire
